// File: logic/msc_pkg.sv
// Shared constants for the motion, sleep and self-test control block.
package msc_pkg;
  // Register word indexes; the byte address is four times the index.
  localparam logic [5:0] IDX_RATE_POWER = 6'h2c;
  localparam logic [5:0] IDX_INT_SOURCE = 6'h30;
  localparam logic [5:0] IDX_FORMAT     = 6'h31;
  localparam logic [5:0] IDX_DATA_FIRST = 6'h32;
  localparam logic [5:0] IDX_DATA_LAST  = 6'h37;
  localparam logic [5:0] IDX_ACT_THR    = 6'h3a;
  localparam logic [5:0] IDX_INACT_THR  = 6'h3b;
  localparam logic [5:0] IDX_INACT_TIME = 6'h3c;
  localparam logic [5:0] IDX_POWER_CTL  = 6'h3d;
  // Field positions.
  localparam int RATE_LSB      = 0;
  localparam int LOW_POWER_BIT = 4;
  localparam int RANGE_LSB     = 0;
  localparam int SCALE_BIT     = 3;
  localparam int FORCE_BIT     = 7;
  localparam int SLEEP_BIT     = 2;
  localparam int AUTOSLEEP_BIT = 4;
  localparam int LINK_BIT      = 5;
  localparam int SRC_DREADY    = 7;
  localparam int SRC_ACT       = 4;
  localparam int SRC_INACT     = 3;
  localparam int SRC_OVERRUN   = 0;
  // Reset values.
  localparam logic [7:0] RATE_POWER_RST = 8'h0a;
  localparam logic [7:0] FORMAT_RST     = 8'h00;
  localparam logic [7:0] POWER_CTL_RST  = 8'h00;
  localparam logic [7:0] THR_RST        = 8'h00;
  // Rate code of the undecimated internal sampling frequency.
  localparam logic [3:0] RATE_FULL      = 4'hf;
  // Decimation used while asleep, as a power of two.
  localparam logic [3:0] SLEEP_LOG2     = 4'hc;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
  // Detection watch states, one-hot.
  typedef enum logic [1:0] {
    MSC_WATCH_INACT = 2'b01,
    MSC_WATCH_ACT   = 2'b10
  } msc_watch_t;
endpackage

// File: logic/msc_dec_if.sv
// Link between the control core and its decimator.
`timescale 1ns/10ps
interface msc_dec_if;
  logic       sample_in;
  logic [3:0] log2_ratio;
  logic       tick;
  modport decim (input sample_in, input log2_ratio, output tick);
  modport user  (output sample_in, output log2_ratio, input tick);
endinterface

// File: logic/msc_decim.sv
// Decimator that derives every output rate from the common sample rate.
`timescale 1ns/10ps
module msc_decim #(
  parameter int CNT_W = 15
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control side.
  msc_dec_if.decim dec
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mask;

  // Low bits of the counter that must all be set for an output tick.
  assign mask = CNT_W'((32'h1 << dec.log2_ratio) - 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if (dec.sample_in) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // A rate change takes effect at the next aligned count, even mid-gap.
  assign dec.tick = dec.sample_in && ((cnt_reg & mask) == mask);
endmodule

// File: logic/msc_top.sv
// Motion-driven sleep control, sample rate decimation and self-test force.
// Operation
// - Lower output rates come from decimating one shared sampling rate.
// - Activity is judged on undecimated samples, not on output words.
// - With link set, activity is sought only after inactivity, alternating.
// - No autosleep while an activity flag stays uncleared.
// - Inactivity with sleep, autosleep, link: low rate, swap to activity watch.
// - Activity while asleep restores rate, flags it, swaps to inactivity.
// - Low power mode and sleep both keep the sample-available flag working.
// - Source read clears activity flags; data read clears sample flags.
// - Force bit applies test force to the sensor; clearing removes it.
`timescale 1ns/10ps
module msc_top (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Undecimated sensor samples.
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_x,
  input  wire logic [15:0] sample_y,
  input  wire logic [15:0] sample_z,
  // Sensor control.
  output logic             test_force,
  output logic             low_power,
  output logic             sleep_active
);
  msc_dec_if dec ();

  logic [7:0]  rate_power_reg, format_reg, power_ctl_reg;
  logic [7:0]  act_thr_reg, inact_thr_reg, inact_time_reg;
  logic [15:0] data_x_reg, data_y_reg, data_z_reg;
  logic        aw_rdy_reg, ar_rdy_reg, bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        dready_flag, overrun_flag, act_flag, inact_flag;
  logic        sleep_reg, force_reg;
  logic [8:0]  quiet_cnt_reg;
  msc_pkg::msc_watch_t watch_reg;
  logic [5:0]  widx, ridx;
  logic        wr_fire, rd_fire, src_read, data_read, wr_hit, rd_hit;
  logic        link, autosleep, sleep_en, act_en, inact_en;
  logic        act_hit, quiet, act_evt, inact_evt, go_sleep;
  logic [15:0] act_lvl, inact_lvl;
  logic [7:0]  rd_byte;

  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(~v + 16'h1) : v;
  endfunction

  // Bus decode; a write is taken in the cycle its ready pair is high.
  assign widx      = awaddr[7:2];
  assign ridx      = araddr[7:2];
  assign wr_fire   = aw_rdy_reg;
  assign rd_fire   = ar_rdy_reg;
  assign src_read  = rd_fire && ridx == msc_pkg::IDX_INT_SOURCE;
  assign data_read = rd_fire && ridx >= msc_pkg::IDX_DATA_FIRST
                     && ridx <= msc_pkg::IDX_DATA_LAST;
  assign wr_hit = widx == msc_pkg::IDX_RATE_POWER
               || widx == msc_pkg::IDX_FORMAT
               || (widx >= msc_pkg::IDX_ACT_THR
                   && widx <= msc_pkg::IDX_POWER_CTL);
  // A read is judged on its own address only, never on the write address.
  assign rd_hit = ridx == msc_pkg::IDX_INT_SOURCE
               || (ridx >= msc_pkg::IDX_DATA_FIRST
                   && ridx <= msc_pkg::IDX_DATA_LAST)
               || ridx == msc_pkg::IDX_RATE_POWER
               || ridx == msc_pkg::IDX_FORMAT
               || (ridx >= msc_pkg::IDX_ACT_THR
                   && ridx <= msc_pkg::IDX_POWER_CTL);

  // Write handshake: both readys rise together once address and data wait.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= msc_pkg::RESP_OKAY;
    end else begin
      aw_rdy_reg <= awvalid && wvalid && !aw_rdy_reg && !bvalid_reg;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? msc_pkg::RESP_OKAY : msc_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Writable registers; only byte lane 0 carries data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_power_reg <= msc_pkg::RATE_POWER_RST;
      format_reg     <= msc_pkg::FORMAT_RST;
      power_ctl_reg  <= msc_pkg::POWER_CTL_RST;
      act_thr_reg    <= msc_pkg::THR_RST;
      inact_thr_reg  <= msc_pkg::THR_RST;
      inact_time_reg <= msc_pkg::THR_RST;
    end else if (wr_fire && wstrb[0]) begin
      case (widx)
        msc_pkg::IDX_RATE_POWER: rate_power_reg <= wdata[7:0];
        msc_pkg::IDX_FORMAT:     format_reg     <= wdata[7:0];
        msc_pkg::IDX_POWER_CTL:  power_ctl_reg  <= wdata[7:0];
        msc_pkg::IDX_ACT_THR:    act_thr_reg    <= wdata[7:0];
        msc_pkg::IDX_INACT_THR:  inact_thr_reg  <= wdata[7:0];
        msc_pkg::IDX_INACT_TIME: inact_time_reg <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data mux; unmapped words read as zero.
  always_comb begin
    case (ridx)
      msc_pkg::IDX_RATE_POWER: rd_byte = rate_power_reg;
      msc_pkg::IDX_INT_SOURCE: rd_byte = {dready_flag, 2'b00, act_flag,
                                          inact_flag, 2'b00, overrun_flag};
      msc_pkg::IDX_FORMAT:     rd_byte = format_reg;
      6'h32:                   rd_byte = data_x_reg[7:0];
      6'h33:                   rd_byte = data_x_reg[15:8];
      6'h34:                   rd_byte = data_y_reg[7:0];
      6'h35:                   rd_byte = data_y_reg[15:8];
      6'h36:                   rd_byte = data_z_reg[7:0];
      6'h37:                   rd_byte = data_z_reg[15:8];
      msc_pkg::IDX_ACT_THR:    rd_byte = act_thr_reg;
      msc_pkg::IDX_INACT_THR:  rd_byte = inact_thr_reg;
      msc_pkg::IDX_INACT_TIME: rd_byte = inact_time_reg;
      msc_pkg::IDX_POWER_CTL:  rd_byte = power_ctl_reg;
      default:                 rd_byte = 8'h00;
    endcase
  end

  // Read handshake; data is captured when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= msc_pkg::RESP_OKAY;
    end else begin
      ar_rdy_reg <= arvalid && !ar_rdy_reg && !rvalid_reg;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {24'h00_0000, rd_byte};
        rresp_reg  <= rd_hit ? msc_pkg::RESP_OKAY : msc_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign link      = power_ctl_reg[msc_pkg::LINK_BIT];
  assign autosleep = power_ctl_reg[msc_pkg::AUTOSLEEP_BIT];
  assign sleep_en  = power_ctl_reg[msc_pkg::SLEEP_BIT];

  assign dec.sample_in  = sample_valid;
  assign dec.log2_ratio = sleep_reg ? msc_pkg::SLEEP_LOG2
    : 4'(msc_pkg::RATE_FULL - rate_power_reg[msc_pkg::RATE_LSB +: 4]);

  msc_decim #(.CNT_W(15)) u_decim (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dec     (dec)
  );

  assign act_lvl   = {4'h0, act_thr_reg, 4'h0};
  assign inact_lvl = {4'h0, inact_thr_reg, 4'h0};
  assign act_hit   = mag(sample_x) > act_lvl || mag(sample_y) > act_lvl
                     || mag(sample_z) > act_lvl;
  assign quiet     = mag(sample_x) <= inact_lvl
                     && mag(sample_y) <= inact_lvl
                     && mag(sample_z) <= inact_lvl;
  assign act_en    = !link || watch_reg == msc_pkg::MSC_WATCH_ACT;
  assign inact_en  = !link || watch_reg == msc_pkg::MSC_WATCH_INACT;
  assign act_evt   = sample_valid && act_en && act_hit;
  assign inact_evt = sample_valid && inact_en && quiet
                     && quiet_cnt_reg == {1'b0, inact_time_reg};
  assign go_sleep  = inact_evt && link && autosleep && !act_flag;

  // Quiet run counter; it stops one past the limit so the event fires once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet_cnt_reg <= 9'h000;
    end else if (!inact_en || (sample_valid && !quiet)) begin
      quiet_cnt_reg <= 9'h000;
    end else if (sample_valid && quiet_cnt_reg <= {1'b0, inact_time_reg}) begin
      quiet_cnt_reg <= quiet_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watch_reg <= msc_pkg::MSC_WATCH_INACT;
    end else begin
      case (watch_reg)
        msc_pkg::MSC_WATCH_INACT: if (link && inact_evt) begin
          watch_reg <= msc_pkg::MSC_WATCH_ACT;
        end
        msc_pkg::MSC_WATCH_ACT: if (link && act_evt) begin
          watch_reg <= msc_pkg::MSC_WATCH_INACT;
        end
        default: watch_reg <= msc_pkg::MSC_WATCH_INACT;
      endcase
    end
  end

  // wake on activity
  // Sleep without autosleep is a fixed low-rate mode chosen by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_reg <= 1'b0;
    end else if (!sleep_en) begin
      sleep_reg <= 1'b0;
    end else if (!autosleep) begin
      sleep_reg <= 1'b1;
    end else if (go_sleep) begin
      sleep_reg <= 1'b1;
    end else if (act_evt) begin
      sleep_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_flag   <= 1'b0;
      inact_flag <= 1'b0;
    end else begin
      act_flag   <= act_evt || (act_flag && !src_read);
      inact_flag <= inact_evt || (inact_flag && !src_read);
    end
  end

  // sample flags in every mode
  // Overrun marks a fresh output word landing on one not yet read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dready_flag  <= 1'b0;
      overrun_flag <= 1'b0;
      data_x_reg   <= 16'h0000;
      data_y_reg   <= 16'h0000;
      data_z_reg   <= 16'h0000;
    end else begin
      dready_flag  <= dec.tick || (dready_flag && !data_read);
      overrun_flag <= (dec.tick && dready_flag)
                      || (overrun_flag && !data_read);
      if (dec.tick) begin
        data_x_reg <= sample_x;
        data_y_reg <= sample_y;
        data_z_reg <= sample_z;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= format_reg[msc_pkg::FORCE_BIT];
    end
  end

  assign awready      = aw_rdy_reg;
  assign wready       = aw_rdy_reg;
  assign bvalid       = bvalid_reg;
  assign bresp        = bresp_reg;
  assign arready      = ar_rdy_reg;
  assign rvalid       = rvalid_reg;
  assign rdata        = rdata_reg;
  assign rresp        = rresp_reg;
  assign test_force   = force_reg;
  assign low_power    = rate_power_reg[msc_pkg::LOW_POWER_BIT];
  assign sleep_active = sleep_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TICK_ON_SAMPLE: assert property (dec.tick |-> sample_valid)
    else $error("Output tick without an internal sample.");
  AST_ACT_RAW: assert property (act_evt |=> act_flag)
    else $error("Raw activity did not set the activity flag.");
  AST_LINK_ALT: assert property (
    link && watch_reg == msc_pkg::MSC_WATCH_ACT |-> !inact_evt)
    else $error("Inactivity seen while linked watch awaits activity.");
  AST_NO_SLEEP_ACT: assert property (
    inact_evt && act_flag && sleep_en && autosleep && !sleep_reg
    |=> !sleep_reg)
    else $error("Entered sleep with activity uncleared.");
  AST_SLEEP_ENTER: assert property (
    go_sleep && sleep_en
    |=> sleep_reg && watch_reg == msc_pkg::MSC_WATCH_ACT)
    else $error("Inactivity did not lower rate and swap watch.");
  AST_WAKE: assert property (
    sleep_reg && sleep_en && autosleep && link && act_evt
    |=> !sleep_reg && act_flag
        && watch_reg == msc_pkg::MSC_WATCH_INACT)
    else $error("Activity did not wake and swap watch.");
  AST_DREADY_SET: assert property (dec.tick |=> dready_flag)
    else $error("Output word did not raise sample flag.");
  AST_SRC_CLEAR: assert property (
    src_read && !act_evt && !inact_evt |=> !act_flag && !inact_flag)
    else $error("Source read left activity flags set.");
  AST_FORCE: assert property (
    wr_fire && wstrb[0] && widx == msc_pkg::IDX_FORMAT
    |=> ##1 force_reg == $past(wdata[7], 2))
    else $error("Test force does not follow its bit.");

  COV_SLEEP: cover property (go_sleep ##[1:1000] sleep_reg && act_evt);
  COV_SRC_READ: cover property (act_flag && src_read);
  COV_OVERRUN: cover property (dec.tick && dready_flag);
  COV_FORCE: cover property ($rose(force_reg));
endmodule

// File: sim/msc_host.sv
// Host bus master model: AXI4-Lite register writes and reads.
`timescale 1ns/10ps
module msc_host (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels.
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Bus idle from time zero, so nothing is offered during reset.
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // One write; ok stays low when no answer comes within the bound.
  task automatic wr(input logic [5:0] idx, input logic [7:0] val,
                    output logic [1:0] resp, output bit ok);
    ok = 1'b0;
    resp = 2'b11;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        resp = bresp;
        ok = 1'b1;
      end
    end
  endtask

  // One read; the answer is taken at the edge where rvalid is seen.
  task automatic rd(input logic [5:0] idx, output logic [31:0] data,
                    output logic [1:0] resp, output bit ok);
    ok = 1'b0;
    data = '0;
    resp = 2'b11;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        data = rdata;
        resp = rresp;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// File: sim/tb_top.sv
// Bench for the motion, sleep and self-test control block.
`timescale 1ns/10ps
module tb_top;
  // Clock, reset and bus wires.
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  // Sensor side and tallies.
  logic        sample_valid, test_force, low_power, sleep_active;
  logic [15:0] sample_x, sample_y, sample_z;
  int          bad_count;
  int          compares;
  // Self-test model: samples per average, still level, force shift.
  localparam int          ST_N     = 10;
  localparam logic [15:0] ST_BASE  = 16'h0008;
  localparam logic [15:0] ST_SHIFT = 16'h0010;

  msc_top u_msc_top (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .test_force(test_force),
    .low_power(low_power), .sleep_active(sleep_active)
  );
  msc_host u_msc_host (
    .aclk(aclk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // Free-running 40 MHz clock.
  always #12.5 aclk = ~aclk;

  // Verdict and end of run, also reached when a wait runs out.
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // Bus wrappers; a lost answer ends the run.
  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    bit ok;
    u_msc_host.wr(idx, val, r, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t write timed out", $time);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [5:0] idx);
    bit ok;
    u_msc_host.rd(idx, d, r, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t read timed out", $time);
      give_verdict();
    end
  endtask

  // One raw sample, the same size on all axes, z negated.
  // The modelled sensor shifts its output while the test force is on.
  task automatic smp(input logic [15:0] x);
    logic [15:0] v;
    @(posedge aclk);
    v = x + (test_force ? ST_SHIFT : 16'h0000);
    sample_valid <= 1'b1;
    sample_x <= v;
    sample_y <= v;
    sample_z <= -v;
    @(posedge aclk);
    sample_valid <= 1'b0;
  endtask

  // Bounded wait for a level on the force or the sleep output.
  task automatic wait_for(input bit on_force, input logic v);
    for (int n = 0;
         n < 8 && (on_force ? test_force : sleep_active) !== v;
         n++) @(posedge aclk);
  endtask

  // Sum of x output words over ST_N still samples, one word per sample.
  task automatic st_avg(output int sum);
    logic [7:0] lo;
    sum = 0;
    for (int k = 0; k < ST_N; k++) begin
      smp(ST_BASE);
      rd(msc_pkg::IDX_DATA_FIRST);
      lo = d[7:0];
      rd(msc_pkg::IDX_DATA_FIRST + 6'h01);
      sum += int'($signed({d[7:0], lo}));
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Reset values, unmapped words and the low power select.
  task automatic t_reset;
    rd(msc_pkg::IDX_RATE_POWER);
    chk(d, 32'h0000000a, "rate reset");
    rd(msc_pkg::IDX_POWER_CTL);
    chk(d, 32'h00000000, "power ctl reset");
    chk({test_force, low_power, sleep_active}, 0, "outputs at reset");
    rd(6'h00);
    chk(d, 32'h0, "unmapped read data");
    chk(r, msc_pkg::RESP_SLVERR, "unmapped read");
    wr(6'h01, 8'h55);
    chk(r, msc_pkg::RESP_SLVERR, "unmapped write");
    wr(msc_pkg::IDX_RATE_POWER, 8'h1a);
    chk(r, msc_pkg::RESP_OKAY, "write response");
    chk(low_power, 1, "low power out");
    rd(6'h01);
    chk(r, msc_pkg::RESP_SLVERR, "unmapped read after write");
  endtask

  // Decimated ticks, data-read clearing and raw activity.
  task automatic t_decim;
    int last;
    int ticks;
    last = -1;
    ticks = 0;
    for (int i = 1; i <= 70; i++) begin
      smp(i[15:0]);
      rd(msc_pkg::IDX_INT_SOURCE);
      if (d[msc_pkg::SRC_DREADY] === 1'b1) begin
        rd(msc_pkg::IDX_DATA_FIRST);
        chk(d, i & 32'hff, "data at tick");
        if (last >= 0) chk(i - last, 32, "tick spacing");
        last = i;
        ticks++;
      end
    end
    chk(ticks >= 2, 1, "ticks in low power");
    wr(msc_pkg::IDX_ACT_THR, 8'h02);
    if ((71 - last) % 32 == 0) smp(16'h0000);
    smp(16'h0064);
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_ACT], 1, "raw activity");
    chk(d[msc_pkg::SRC_DREADY], 0, "no output word");
    rd(msc_pkg::IDX_DATA_FIRST);
    chk(d, last & 32'hff, "output word kept");
  endtask

  // Linked sleep and wake with autosleep.
  task automatic t_link;
    do_reset();
    wr(msc_pkg::IDX_ACT_THR, 8'h02);
    wr(msc_pkg::IDX_INACT_THR, 8'h02);
    wr(msc_pkg::IDX_INACT_TIME, 8'h03);
    wr(msc_pkg::IDX_POWER_CTL, 8'h34);
    smp(16'h0064);
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_ACT], 0, "activity before inactivity");
    repeat (4) smp(16'h0000);
    wait_for(1'b0, 1'b1);
    chk(sleep_active, 1, "sleep entry");
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_INACT], 1, "inactivity flag");
    repeat (8) smp(16'h0000);
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_INACT], 0, "no repeated inactivity");
    smp(16'h0064);
    wait_for(1'b0, 1'b0);
    chk(sleep_active, 0, "wake on activity");
    repeat (6) smp(16'h0000);
    chk(sleep_active, 0, "no sleep with activity pending");
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_ACT], 1, "activity flag on wake");
  endtask

  // Self-test: force-off and force-on averages with the sensor held still.
  // Full rate keeps one output word per sample, so no decimation gaps.
  task automatic t_selftest;
    int off_sum;
    int on_sum;
    wr(msc_pkg::IDX_RATE_POWER, 8'h0f);
    chk(low_power, 0, "normal power");
    wr(msc_pkg::IDX_FORMAT, 8'h0b);
    st_avg(off_sum);
    chk(off_sum / ST_N, ST_BASE, "force-off average");
    wr(msc_pkg::IDX_FORMAT, 8'h8b);
    wait_for(1'b1, 1'b1);
    chk(test_force, 1, "force applied");
    rd(msc_pkg::IDX_FORMAT);
    chk(d, 32'h0000008b, "format readback");
    repeat (4) smp(ST_BASE);
    st_avg(on_sum);
    chk((on_sum - off_sum) / ST_N, ST_SHIFT, "self-test change");
    rd(msc_pkg::IDX_INT_SOURCE);
    chk(d[msc_pkg::SRC_ACT], 0, "no motion during test");
    wr(msc_pkg::IDX_FORMAT, 8'h0b);
    wait_for(1'b1, 1'b0);
    chk(test_force, 0, "force removed");
  endtask

  // Main sequence.
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    sample_valid = 1'b0;
    {sample_x, sample_y, sample_z} = '0;
    do_reset();
    t_reset();
    t_decim();
    t_link();
    t_selftest();
    give_verdict();
  end
endmodule
